// [sse_defines.svh]
// Offsets, encodings and bit positions of the stored sequence engine.
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH
`define SSE_OFF_CTRL   8'h00
`define SSE_OFF_DATA   8'h04
`define SSE_OFF_STAT   8'h08
`define SSE_OFF_LIST   8'h0c
`define SSE_OFF_DMODE  8'h10
`define SSE_OFF_DPOS   8'h14
`define SSE_H_DEF      4'h1
`define SSE_H_END      4'h2
`define SSE_H_EXEC     4'h3
`define SSE_H_LIST     4'h4
`define SSE_H_UNDEF    4'h5
`define SSE_H_BACKUP   4'h6
`define SSE_H_AUTO     4'h7
`define SSE_H_AUTO_OFF 4'h8
`define SSE_HCMD_HI    7
`define SSE_HCMD_LO    4
`define SSE_OP_END     4'h0
`define SSE_OP_XS      4'h1
`define SSE_OP_IFF     4'h2
`define SSE_OP_IFT     4'h3
`define SSE_OP_WAIT    4'h4
`define SSE_OP_MOVE    4'h5
`define SSE_OP_HOME    4'h6
`define SSE_CH_CTRLC   8'h03
`define SSE_CH_ESC     8'h1b
`define SSE_SEQ_MAX    7'h7f
`define SSE_MEM_LAST   10'h3ff
`define SSE_ST_RUN     0
`define SSE_ST_WAIT    1
`define SSE_ST_DEF     2
`define SSE_ST_DOT     3
`define SSE_ST_BUSY    4
`define SSE_ST_HOME    5
`define SSE_ST_DATUM   6
`define SSE_DM_ARM     0
`define SSE_DM_EVERY   1
`define SSE_DM_CLR     2
`define SSE_AUTO_EN    3
`endif

// [sse_pkg.sv]
// Types shared by the stored sequence engine.
package sse_pkg;
    typedef enum logic [2:0] {
        S_LOAD,
        S_IDLE,
        S_RUN,
        S_WAIT,
        S_MOTION,
        S_BACKUP
    } sse_state_e;
    typedef struct packed {
        logic [3:0]  op;
        logic [15:0] arg;
    } sse_word_s;
endpackage

// [sse_engine.sv]
// Stored command sequence engine with datum capture and status flags.
`timescale 1ns/1ps
`include "sse_defines.svh"
// What this block does
// - Datum is low when switch active or index low, else high.
// - Status query shows the combined datum signal at bit 6.
// - Datum position is captured only on a rising datum edge.
// - Dot lights after capture; home indication during home moves.
// - Sequences start on host prompt or at power-up when auto is enabled.
// - Eight slots 0 to 7, each at most 127 commands, chosen by number.
// - Define, end, execute, list, undefine, backup, auto and disable.
// - Execute inside a sequence jumps to the named sequence, no return.
// - After a jump, commands run from the first to the end marker.
// - Control-C or escape halts the move and returns to idle.
// - Definitions are volatile until backup copies them to flash.
// - Enabled auto sequence starts at power-up; disable cancels it.
// - Only one sequence is selected for power-up execution.
// - A waiting indication shows while a wait command holds.
// - Pattern gives ports 8 to 1; 1 high, 0 low, 2 ignore.
// - If-false runs next command when false, skips it when true.
// - If-true runs next command on match, skips it otherwise.
// - Single capture happens once unless mode selects every passage.
module sse_engine
    import sse_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        datum_stop_switch_input_i,
    input  wire logic        index_i,
    input  wire logic [7:0]  read_port_i,
    input  wire logic [31:0] position_i,
    input  wire logic        motion_done_i,
    output logic             cmd_valid_o,
    output sse_word_s        cmd_o,
    output logic             halt_o,
    output logic             dot_o,
    output logic             home_ind_o,
    output logic             wait_ind_o
);

    // Pattern word: high byte marks ports that matter, low byte their level.
    function automatic logic pat_hit(input logic [15:0] pat,
                                     input logic [7:0]  prt);
        pat_hit = &(~pat[15:8] | ~(prt ^ pat[7:0]));
    endfunction

    function automatic logic [9:0] seq_base(input logic [2:0] n);
        seq_base = {n, 7'h00};
    endfunction

    // Steps stay inside the slot so a skip can never run into the next one.
    function automatic logic [9:0] pc_step(input logic [9:0] pc,
                                           input logic [1:0] st);
        pc_step = {pc[9:7], pc[6:0] + {5'h00, st}};
    endfunction

    sse_word_s   vol_mem   [0:1023];
    sse_word_s   flash_mem [0:1023];
    sse_state_e  st_reg;
    sse_state_e  st_next;
    logic [9:0]  pc_reg;
    logic [9:0]  pc_next;
    logic [9:0]  cp_reg;
    logic [9:0]  def_ptr_reg;
    logic [9:0]  list_ptr_reg;
    logic        def_reg;
    logic [3:0]  auto_reg;
    logic [1:0]  sw_sync_reg;
    logic [1:0]  ix_sync_reg;
    logic [7:0]  prt_s1_reg;
    logic [7:0]  prt_s2_reg;
    logic        datum_q_reg;
    logic        armed_reg;
    logic        every_reg;
    logic        capt_reg;
    logic [31:0] dpos_reg;
    logic        home_reg;
    logic        wait_reg;
    logic        issue;
    logic [31:0] rdata_next;
    sse_word_s   cur;
    sse_word_s   vol_wd;
    logic [9:0]  vol_wa;
    logic        vol_we;
    assign cur = vol_mem[pc_reg];

    // Pins cross into the clock domain through two flip-flops each.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_sync_reg <= 2'h0;
            ix_sync_reg <= 2'h0;
            prt_s1_reg  <= 8'h00;
            prt_s2_reg  <= 8'h00;
        end else begin
            sw_sync_reg <= {sw_sync_reg[0], datum_stop_switch_input_i};
            ix_sync_reg <= {ix_sync_reg[0], index_i};
            prt_s1_reg  <= read_port_i;
            prt_s2_reg  <= prt_s1_reg;
        end
    end

    wire datum = ~sw_sync_reg[1] & ix_sync_reg[1];

    wire abort = rx_valid_i & ((rx_byte_i == `SSE_CH_CTRLC) |
                               (rx_byte_i == `SSE_CH_ESC));
    wire running = (st_reg == S_RUN) | (st_reg == S_WAIT) |
                   (st_reg == S_MOTION);

    // Host commands are taken only while idle, so a listing or an edit
    // never races a running sequence.
    wire       idle  = st_reg == S_IDLE;
    wire       hw    = wr_i & idle & (addr_i == `SSE_OFF_CTRL);
    wire [3:0] hcmd  = wdata_i[`SSE_HCMD_HI:`SSE_HCMD_LO];
    wire [2:0] hn    = wdata_i[2:0];
    wire       h_def = hw & (hcmd == `SSE_H_DEF);
    wire       h_end = hw & (hcmd == `SSE_H_END) & def_reg;
    wire       h_ex  = hw & (hcmd == `SSE_H_EXEC);
    wire       h_ls  = hw & (hcmd == `SSE_H_LIST);
    wire       h_un  = hw & (hcmd == `SSE_H_UNDEF);
    wire       h_bk  = hw & (hcmd == `SSE_H_BACKUP);
    wire       h_ae  = hw & (hcmd == `SSE_H_AUTO);
    wire       h_ad  = hw & (hcmd == `SSE_H_AUTO_OFF);
    wire       d_wr  = wr_i & idle & def_reg & (addr_i == `SSE_OFF_DATA) &
                       (def_ptr_reg[6:0] != `SSE_SEQ_MAX);
    wire       dm_wr = wr_i & (addr_i == `SSE_OFF_DMODE);
    wire       l_rd  = rd_i & (addr_i == `SSE_OFF_LIST);

    wire pat_now = pat_hit(cur.arg, prt_s2_reg);

    // Sequencer.
    always_comb begin
        st_next = st_reg;
        pc_next = pc_reg;
        issue   = 1'b0;
        case (st_reg)
            S_LOAD: begin
                if (cp_reg == `SSE_MEM_LAST) begin
                    st_next = S_IDLE;
                    // An unknown select after power-up counts as disabled.
                    if (auto_reg[`SSE_AUTO_EN]) begin
                        st_next = S_RUN;
                        pc_next = seq_base(auto_reg[2:0]);
                    end
                end
            end
            S_BACKUP: st_next = (cp_reg == `SSE_MEM_LAST) ? S_IDLE : S_BACKUP;
            S_IDLE: begin
                if (h_ex) begin
                    st_next = S_RUN;
                    pc_next = seq_base(hn);
                end else if (h_bk) begin
                    st_next = S_BACKUP;
                end
            end
            S_RUN: begin
                case (cur.op)
                    `SSE_OP_XS: pc_next = seq_base(cur.arg[2:0]);
                    `SSE_OP_IFF: begin
                        pc_next = pc_step(pc_reg, pat_now ? 2'd2 : 2'd1);
                    end
                    `SSE_OP_IFT: begin
                        pc_next = pc_step(pc_reg, pat_now ? 2'd1 : 2'd2);
                    end
                    `SSE_OP_WAIT: st_next = S_WAIT;
                    `SSE_OP_MOVE, `SSE_OP_HOME: begin
                        issue   = 1'b1;
                        st_next = S_MOTION;
                        pc_next = pc_step(pc_reg, 2'd1);
                    end
                    default: st_next = S_IDLE;
                endcase
            end
            S_WAIT: begin
                if (pat_now) begin
                    st_next = S_RUN;
                    pc_next = pc_step(pc_reg, 2'd1);
                end
            end
            S_MOTION: st_next = motion_done_i ? S_RUN : S_MOTION;
            default: st_next = S_IDLE;
        endcase
        if (abort & running) begin
            st_next = S_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= S_LOAD;
            pc_reg <= 10'h000;
            cp_reg <= 10'h000;
        end else begin
            st_reg <= st_next;
            pc_reg <= pc_next;
            cp_reg <= ((st_reg == S_LOAD) | (st_reg == S_BACKUP)) ?
                      cp_reg + 10'h001 : 10'h000;
        end
    end

    // Volatile store has one write port shared by load, edit and undefine.
    wire ld = st_reg == S_LOAD;
    assign vol_we = ld | d_wr | h_end | h_un;
    assign vol_wa = ld ? cp_reg :
                    h_un ? seq_base(hn) : def_ptr_reg;
    assign vol_wd = ld ? flash_mem[cp_reg] :
                    d_wr ? sse_word_s'(wdata_i[19:0]) :
                    sse_word_s'({`SSE_OP_END, 16'h0000});

    // Stores carry no reset: their contents must outlive a reset.
    always_ff @(posedge clk_sys_i) begin
        if (vol_we) begin
            vol_mem[vol_wa] <= vol_wd;
        end
        if (st_reg == S_BACKUP) begin
            flash_mem[cp_reg] <= vol_mem[cp_reg];
        end
        if (h_ae) begin
            auto_reg <= {1'b1, hn};
        end else if (h_ad) begin
            auto_reg <= 4'h0;
        end
    end

    // Definition and listing pointers.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            def_reg      <= 1'b0;
            def_ptr_reg  <= 10'h000;
            list_ptr_reg <= 10'h000;
        end else begin
            if (h_def) begin
                def_reg     <= 1'b1;
                def_ptr_reg <= seq_base(hn);
            end else if (h_end) begin
                def_reg <= 1'b0;
            end else if (d_wr) begin
                def_ptr_reg <= pc_step(def_ptr_reg, 2'd1);
            end
            if (h_ls) begin
                list_ptr_reg <= seq_base(hn);
            end else if (l_rd) begin
                list_ptr_reg <= pc_step(list_ptr_reg, 2'd1);
            end
        end
    end

    // Datum capture.
    wire rise = datum & ~datum_q_reg;
    wire take = rise & (armed_reg | every_reg);
    wire home_go = issue & (cur.op == `SSE_OP_HOME);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            datum_q_reg <= 1'b0;
            armed_reg   <= 1'b0;
            every_reg   <= 1'b0;
            capt_reg    <= 1'b0;
            dpos_reg    <= 32'h0000_0000;
        end else begin
            datum_q_reg <= datum;
            if (dm_wr) begin
                every_reg <= wdata_i[`SSE_DM_EVERY];
            end
            if (take) begin
                armed_reg <= 1'b0;
            end else if (home_go | (dm_wr & wdata_i[`SSE_DM_ARM])) begin
                armed_reg <= 1'b1;
            end
            if (take) begin
                capt_reg <= 1'b1;
                dpos_reg <= position_i;
            end else if (dm_wr & wdata_i[`SSE_DM_CLR]) begin
                capt_reg <= 1'b0;
            end
        end
    end

    // Outputs toward the motion engine and the display.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o       <= '0;
            halt_o      <= 1'b0;
            home_reg    <= 1'b0;
            wait_reg    <= 1'b0;
        end else begin
            cmd_valid_o <= issue;
            if (issue) begin
                cmd_o <= cur;
            end
            halt_o   <= abort & running;
            home_reg <= (st_next == S_MOTION) & (home_go | home_reg);
            wait_reg <= st_next == S_WAIT;
        end
    end

    assign dot_o      = capt_reg;
    assign home_ind_o = home_reg;
    assign wait_ind_o = wait_reg;

    // Read side.
    wire [31:0] stat = {25'h0000000, datum, home_reg, ~(idle | running),
                        capt_reg, def_reg, wait_reg, running};

    always_comb begin
        case (addr_i)
            `SSE_OFF_STAT: rdata_next = stat;
            `SSE_OFF_LIST: rdata_next = {12'h000, vol_mem[list_ptr_reg]};
            `SSE_OFF_DMODE: rdata_next = {30'h0, every_reg, armed_reg};
            `SSE_OFF_DPOS: rdata_next = dpos_reg;
            `SSE_OFF_CTRL: rdata_next = {28'h0, auto_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? rdata_next : 32'h0000_0000;
        end
    end

endmodule

// [sse_engine_chk.sv]
// Port-level property checker for the stored sequence engine.
`timescale 1ns/1ps
`include "sse_defines.svh"
module sse_engine_chk
    import sse_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        rx_valid_i,
    input wire logic [7:0]  rx_byte_i,
    input wire logic        cmd_valid_o,
    input wire sse_word_s   cmd_o,
    input wire logic        halt_o,
    input wire logic        dot_o,
    input wire logic        home_ind_o,
    input wire logic        wait_ind_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic clr_req;
    assign clr_req = wr_i && addr_i == `SSE_OFF_DMODE && wdata_i[`SSE_DM_CLR];
    a_rdata_quiet: assert property (
        !$past(rd_i) |-> rdata_o == 32'h0) else $error("stray read data");
    a_halt_cause: assert property (
        halt_o |-> $past(rx_valid_i) && ($past(rx_byte_i) == `SSE_CH_CTRLC
        || $past(rx_byte_i) == `SSE_CH_ESC)) else $error("halt without abort");
    a_halt_pulse: assert property (
        halt_o |=> !halt_o) else $error("halt longer than one cycle");
    a_abort_idle: assert property (
        halt_o |=> !wait_ind_o && !cmd_valid_o) else $error("busy after halt");
    a_cmd_pulse: assert property (
        cmd_valid_o |=> !cmd_valid_o) else $error("command strobe too long");
    a_cmd_hold: assert property (
        !cmd_valid_o |-> $stable(cmd_o)) else $error("command word moved");
    a_home_shown: assert property (
        cmd_valid_o && cmd_o.op == `SSE_OP_HOME |-> ##[0:1] home_ind_o)
        else $error("home indication missing");
    a_dot_kept: assert property (
        dot_o && !clr_req |=> dot_o) else $error("dot lost");
    a_wait_quiet: assert property (
        wait_ind_o |-> !cmd_valid_o) else $error("command while waiting");
    c_home: cover property (cmd_valid_o && cmd_o.op == `SSE_OP_HOME);
    c_halt: cover property (halt_o);
    c_dot: cover property ($rose(dot_o));
endmodule
bind sse_engine sse_engine_chk i_sse_engine_chk (
    .clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rx_valid_i, .rx_byte_i, .cmd_valid_o, .cmd_o, .halt_o, .dot_o,
    .home_ind_o, .wait_ind_o
);

// [sse_motion_model.sv]
// Far-side model of the motion engine answering issued commands.
`timescale 1ns/1ps
module sse_motion_model (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    input  wire logic       cmd_valid_i,
    input  wire logic       halt_i,
    input  wire logic [7:0] delay_i,
    output logic            motion_done_o
);
    logic [7:0] cnt_reg;
    logic       busy_reg;
    // A halted move never reports completion, as a stopped axis would not.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 8'h00;
            busy_reg <= 1'b0;
            motion_done_o <= 1'b0;
        end else begin
            motion_done_o <= 1'b0;
            if (halt_i) begin
                busy_reg <= 1'b0;
            end else if (cmd_valid_i) begin
                busy_reg <= 1'b1;
                cnt_reg <= delay_i;
            end else if (busy_reg && cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
                motion_done_o <= 1'b1;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the stored sequence engine.
`timescale 1ns/1ps
`include "sse_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    $display("mismatch %s exp %0h got %0h", nm, e, g); error_cnt++; end end
module tb import sse_pkg::*; ;
    logic        clk_sys_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        rx_valid_i = 1'b0;
    logic [7:0]  rx_byte_i = 8'h00;
    logic        sw_i = 1'b0;
    logic        index_i = 1'b0;
    logic [7:0]  read_port_i = 8'h00;
    logic [31:0] position_i = 32'h0;
    logic [7:0]  delay = 8'h00;
    logic        motion_done_i;
    logic [31:0] rdata_o;
    logic        cmd_valid_o;
    logic        halt_o;
    logic        dot_o;
    logic        home_ind_o;
    logic        wait_ind_o;
    sse_word_s   cmd_o;
    logic [19:0] log_q[$];
    int          error_cnt = 0;
    int          n_compared = 0;
    int          halt_cnt = 0;
    int          home_cnt = 0;
    int          seed = 32'h368a5bf8;
    sse_engine i_sse_engine (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .rx_valid_i, .rx_byte_i, .index_i, .read_port_i,
        .datum_stop_switch_input_i(sw_i), .position_i, .motion_done_i,
        .cmd_valid_o, .cmd_o, .halt_o, .dot_o, .home_ind_o, .wait_ind_o);
    sse_motion_model i_sse_motion_model (.clk_sys_i, .rst_b_i,
        .cmd_valid_i(cmd_valid_o), .halt_i(halt_o), .delay_i(delay),
        .motion_done_o(motion_done_i));
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (cmd_valid_o) log_q.push_back(cmd_o);
        if (halt_o) halt_cnt++;
        if (home_ind_o) home_cnt++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick(1);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        tick(1);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        tick(1);
        addr_i <= a;
        rd_i <= 1'b1;
        tick(1);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata_o;
    endtask
    task automatic ctl(input logic [3:0] c, input logic [2:0] n);
        wr(`SSE_OFF_CTRL, {24'h0, c, 1'b0, n});
    endtask
    function automatic logic [31:0] w(input logic [3:0] op, logic [15:0] a);
        return {12'h0, op, a};
    endfunction
    function automatic logic hit(input logic [15:0] p, input logic [7:0] v);
        return ((v ^ p[7:0]) & p[15:8]) == 8'h00;
    endfunction
    task automatic def(input logic [2:0] n, input logic [31:0] q[$]);
        ctl(`SSE_H_DEF, n);
        foreach (q[i]) wr(`SSE_OFF_DATA, q[i]);
        ctl(`SSE_H_END, 3'h0);
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 2000 && (s[0] | s[4]) !== 1'b0; i++)
            rd(`SSE_OFF_STAT, s);
        `CHK("idle", 1'b0, s[0] | s[4])
    endtask
    task automatic chk_log(input logic [31:0] q[$]);
        `CHK("count", q.size(), log_q.size())
        foreach (q[i]) `CHK("cmd", q[i][19:0], log_q[i])
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
    initial begin
        logic [31:0] d;
        logic [31:0] p;
        logic [15:0] a[3];
        logic [7:0]  ab[3];
        logic [31:0] ex[$];
        tick(8);
        rst_b_i <= 1'b1;
        wait_idle();
        rd(8'h20, d);
        `CHK("unmapped", 32'h0, d)
        for (int k = 0; k < 4; k++) begin
            tick(1);
            sw_i <= k[1];
            index_i <= k[0];
            tick(4);
            rd(`SSE_OFF_STAT, d);
            `CHK("datum", ~k[1] & k[0], d[`SSE_ST_DATUM])
        end
        // Each pass clears the dot first; pass 1 is single mode, disarmed.
        for (int k = 0; k < 4; k++) begin
            wr(`SSE_OFF_DMODE, k == 0 ? 32'h5 : k == 1 ? 32'h4 : 32'h6);
            tick(1);
            sw_i <= 1'b0;
            index_i <= 1'b0;
            p = $random(seed);
            position_i <= p;
            tick(4);
            index_i <= 1'b1;
            tick(5);
            `CHK("dot", k != 1, dot_o)
            rd(`SSE_OFF_DPOS, d);
            if (k != 1) `CHK("pos", p, d)
        end
        rd(`SSE_OFF_DMODE, d);
        `CHK("dmode", 32'h2, d)
        foreach (a[i]) a[i] = 16'($random(seed));
        def(3'h1, {w(`SSE_OP_WAIT, 16'h0101), w(`SSE_OP_MOVE, a[0]),
            w(`SSE_OP_IFT, 16'h0303), w(`SSE_OP_MOVE, a[1]),
            w(`SSE_OP_IFF, 16'h0303), w(`SSE_OP_MOVE, a[2]),
            w(`SSE_OP_XS, 16'h0002)});
        def(3'h2, {w(`SSE_OP_HOME, 16'h0)});
        def(3'h3, {w(`SSE_OP_MOVE, a[0]), w(`SSE_OP_XS, 16'h0003)});
        ex = {w(`SSE_OP_MOVE, a[0]), w(`SSE_OP_XS, 16'h0003), 32'h0};
        ctl(`SSE_H_LIST, 3'h3);
        foreach (ex[i]) begin
            rd(`SSE_OFF_LIST, d);
            `CHK("list", ex[i], d)
        end
        // A full slot refuses word 128 and keeps room for the end marker.
        ctl(`SSE_H_DEF, 3'h4);
        for (int i = 0; i < 130; i++)
            wr(`SSE_OFF_DATA, w(`SSE_OP_MOVE, 16'(i)));
        ctl(`SSE_H_END, 3'h0);
        ctl(`SSE_H_LIST, 3'h4);
        for (int i = 0; i < 128; i++) begin
            rd(`SSE_OFF_LIST, d);
            p = (i < 127) ? w(`SSE_OP_MOVE, 16'd126) : 32'h0;
            if (i > 125) `CHK("full", p, d)
        end
        for (int k = 0; k < 2; k++) begin
            tick(1);
            read_port_i <= 8'h00;
            delay <= k ? 8'h00 : 8'h10 | 8'($random(seed));
            log_q.delete();
            home_cnt = 0;
            ctl(`SSE_H_EXEC, 3'h1);
            tick(6);
            `CHK("wait", 1'b1, wait_ind_o)
            read_port_i <= k ? 8'h01 : 8'h03;
            wait_idle();
            ex = {w(`SSE_OP_MOVE, a[0]), w(`SSE_OP_MOVE,
                hit(16'h0303, read_port_i) ? a[1] : a[2]),
                w(`SSE_OP_HOME, 16'h0)};
            chk_log(ex);
            `CHK("home", int'(delay) + 3, home_cnt)
            `CHK("home off", 1'b0, home_ind_o)
        end
        ab = '{8'h41, `SSE_CH_CTRLC, `SSE_CH_ESC};
        delay <= 8'hc8;
        foreach (ab[i]) begin
            ctl(`SSE_H_EXEC, 3'h3);
            tick(10);
            halt_cnt = 0;
            rx_valid_i <= 1'b1;
            rx_byte_i <= ab[i];
            tick(1);
            rx_valid_i <= 1'b0;
            tick(3);
            `CHK("halt", i != 0, halt_cnt == 1)
            rd(`SSE_OFF_STAT, d);
            `CHK("run", i == 0, d[`SSE_ST_RUN])
        end
        ctl(`SSE_H_BACKUP, 3'h0);
        wait_idle();
        ctl(`SSE_H_AUTO, 3'h1);
        ctl(`SSE_H_AUTO, 3'h2);
        rd(`SSE_OFF_CTRL, d);
        `CHK("auto", 32'ha, d)
        ctl(`SSE_H_UNDEF, 3'h2);
        for (int k = 0; k < 2; k++) begin
            if (k) ctl(`SSE_H_AUTO_OFF, 3'h0);
            tick(1);
            delay <= 8'h03;
            rst_b_i <= 1'b0;
            tick(2);
            rst_b_i <= 1'b1;
            log_q.delete();
            wait_idle();
            ex = {};
            if (!k) ex = {w(`SSE_OP_HOME, 16'h0)};
            chk_log(ex);
        end
        final_report();
    end
endmodule
